// ---- lfosc_params.svh ----
// Constants for the low-frequency and external oscillator control block
`ifndef LFOSC_PARAMS_SVH
`define LFOSC_PARAMS_SVH

`define LF_CTRL_ADDR     8'h86
`define EXT_CTRL_ADDR    8'hb1
`define LF_EN_BIT        7
`define LF_RDY_BIT       6
`define LF_TRIM_MSB      5
`define LF_TRIM_LSB      2
`define LF_DIV_MSB       1
`define LF_DIV_LSB       0
`define EXT_VLD_BIT      7
`define EXT_MODE_MSB     6
`define EXT_MODE_LSB     4
`define EXT_FREQ_MSB     2
`define EXT_FREQ_LSB     0

`define LF_DIV_RST       2'h0
`define LF_DIV_BY8       2'h0
`define LF_DIV_BY4       2'h1
`define LF_DIV_BY2       2'h2
`define LF_DIV_BY1       2'h3
`define LF_TRIM_RST      4'h8
`define EXT_MODE_RST     3'h0
`define EXT_FREQ_RST     3'h0

`define EXT_MODE_CMOS    3'h2
`define EXT_MODE_CMOS2   3'h3
`define EXT_MODE_RC2     3'h4
`define EXT_MODE_CAP2    3'h5
`define EXT_MODE_XTAL    3'h6
`define EXT_MODE_OSC_PIN_OUT   3'h7

`define SYS_CLK_HZ       20000000
`define LF_NOM_HZ        80000
`define LF_HALF_NOM      (`SYS_CLK_HZ / (2 * `LF_NOM_HZ))
`define LF_TRIM_STEP     4
`define LF_HALF_BASE     (`LF_HALF_NOM - 8 * `LF_TRIM_STEP)
`define LF_SETTLE_EDGES  2
`define EXT_VALID_EDGES  16

`endif

// ---- lfosc_pkg.sv ----
// Types shared by the oscillator control block
package lfosc_pkg;

  typedef struct packed {
    logic       en;
    logic [3:0] trim;
    logic [1:0] div;
  } lf_ctrl_s;

  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] freq;
  } ext_ctrl_s;

  typedef enum logic [2:0] {
    EXT_OFF   = 3'b001,
    EXT_WAIT  = 3'b010,
    EXT_VALID = 3'b100
  } ext_state_e;

endpackage

// ---- lfosc_ctrl.sv ----
// Low-frequency oscillator and external oscillator control, SFR slave
`timescale 1ns/100ps
`default_nettype none
`include "lfosc_params.svh"

// What this block and its firmware do
// [RULE1] Enable bit 7 runs or stops oscillator
// [RULE2] Bit 6 reads oscillator stabilized flag
// [RULE3] Ready cleared only by reset, divider change
// [RULE4] Trim bits 5:2, zero fastest, max slowest
// [RULE5] Firmware trims only while oscillator disabled
// [RULE6] Divider bits 1:0 divide by 8,4,2,1
// [RULE7] Register at 0x86, on every page
// [RULE8] Crystal uses both pins, others one
// [RULE9] External clock selectable as system clock
// [RULE10] Firmware picks crystal mode and range
// [RULE11] Divide-by-two stage gives 50% duty
// [RULE12] Readable valid flag for external clock
// [RULE13] Firmware sets pins analog, latches high
// [RULE14] Firmware waits 1 ms, polls valid
// [RULE15] Nominal 80 kHz before the divider
// [RULE16] Ready sets again after divider settles
module lfosc_ctrl
  import lfosc_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  output var  logic [7:0] sfr_rdata_o,
  input  wire logic       osc_pin_out_i,
  input  wire logic       sysclk_ext_sel_i,
  output var  logic       lf_clk_o,
  output var  logic       ext_clk_o,
  output var  logic       sysclk_src_ext_o,
  output var  logic       osc_pin_in_claim_o,
  output var  logic       osc_pin_out_claim_o
);

  function automatic logic ext_is_div2(input logic [2:0] m);
    ext_is_div2 = (m == `EXT_MODE_CMOS2) || (m == `EXT_MODE_RC2) ||
                  (m == `EXT_MODE_CAP2)  || (m == `EXT_MODE_OSC_PIN_OUT);
  endfunction

  function automatic logic ext_is_xtal(input logic [2:0] m);
    ext_is_xtal = (m == `EXT_MODE_XTAL) || (m == `EXT_MODE_OSC_PIN_OUT);
  endfunction

  lf_ctrl_s   lf_ctrl_q;
  ext_ctrl_s  ext_ctrl_q;
  ext_state_e ext_state_q;
  ext_state_e ext_state_d;
  logic [7:0] lf_cnt_q;
  logic       lf_raw_q;
  logic [2:0] lf_div_cnt_q;
  logic       lf_clk_q;
  logic [1:0] lf_settle_q;
  logic       lf_rdy_q;
  logic       pin_q;
  logic       ext_half_q;
  logic       ext_clk_q;
  logic [4:0] ext_edge_q;
  logic       src_ext_q;
  logic       in_claim_q;
  logic       out_claim_q;
  logic [7:0] rdata_q;

  // No page input: both registers decode on address alone
  wire        lf_sel     = (sfr_addr_i == `LF_CTRL_ADDR);  // see [RULE7]
  wire        ext_sel    = (sfr_addr_i == `EXT_CTRL_ADDR);
  wire        lf_wr      = sfr_wr_i && lf_sel;
  wire        ext_wr     = sfr_wr_i && ext_sel;
  wire        ext_restart = ext_wr && (sfr_wdata_i[`EXT_MODE_MSB:`EXT_MODE_LSB] != ext_ctrl_q.mode);
  wire        div_chg    = lf_wr && (sfr_wdata_i[`LF_DIV_MSB:`LF_DIV_LSB] != lf_ctrl_q.div);  // see [RULE3]
  // Trim stretches each half period; the middle code gives nominal rate
  wire [7:0]  lf_half    = 8'(`LF_HALF_BASE) + {2'h0, lf_ctrl_q.trim, 2'h0};  // see [RULE4] see [RULE15]
  wire        lf_wrap    = lf_ctrl_q.en && (lf_cnt_q == lf_half - 8'h01);
  wire        lf_rise    = lf_wrap && !lf_raw_q;
  wire        lf_div_sel = (lf_ctrl_q.div == `LF_DIV_BY1) ? lf_raw_q :
                           (lf_ctrl_q.div == `LF_DIV_BY2) ? lf_div_cnt_q[0] :
                           (lf_ctrl_q.div == `LF_DIV_BY4) ? lf_div_cnt_q[1] :
                                                            lf_div_cnt_q[2];  // see [RULE6]
  wire        lf_out_rise = lf_div_sel && !lf_clk_q;
  wire        lf_settled  = lf_out_rise && (lf_settle_q == 2'(`LF_SETTLE_EDGES - 1));
  wire        ext_on     = (ext_ctrl_q.mode[2:1] != 2'h0);
  wire        ext_div2   = ext_is_div2(ext_ctrl_q.mode);
  wire        ext_rise   = osc_pin_out_i && !pin_q;
  wire        ext_edges_done = ext_rise && (ext_edge_q == 5'(`EXT_VALID_EDGES - 1));
  wire        ext_valid  = (ext_state_q == EXT_VALID);
  wire [7:0]  lf_rd_word  = {lf_ctrl_q.en, lf_rdy_q, lf_ctrl_q.trim, lf_ctrl_q.div};
  wire [7:0]  ext_rd_word = {ext_valid, ext_ctrl_q.mode, 1'b0, ext_ctrl_q.freq};
  wire [7:0]  rdata_d    = lf_sel ? lf_rd_word : ext_sel ? ext_rd_word : 8'h00;

  always_comb
  begin
    ext_state_d = ext_state_q;
    unique case (ext_state_q)
      EXT_OFF:   if (ext_on) ext_state_d = EXT_WAIT;
      EXT_WAIT:  if (ext_edges_done) ext_state_d = EXT_VALID;  // see [RULE12]
      EXT_VALID: ext_state_d = EXT_VALID;
      default:   ext_state_d = EXT_OFF;
    endcase
    // A new mode write restarts qualification of the clock
    if (!ext_on)
      ext_state_d = EXT_OFF;
    else if (ext_restart)
      ext_state_d = EXT_WAIT;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lf_ctrl_q  <= '{en: 1'b0, trim: `LF_TRIM_RST, div: `LF_DIV_RST};
      ext_ctrl_q <= '{mode: `EXT_MODE_RST, freq: `EXT_FREQ_RST};
      rdata_q    <= 8'h00;
    end
    else
    begin
      if (lf_wr)
        lf_ctrl_q <= '{en:   sfr_wdata_i[`LF_EN_BIT],  // see [RULE1]
                       trim: sfr_wdata_i[`LF_TRIM_MSB:`LF_TRIM_LSB],
                       div:  sfr_wdata_i[`LF_DIV_MSB:`LF_DIV_LSB]};
      if (ext_wr)
        ext_ctrl_q <= '{mode: sfr_wdata_i[`EXT_MODE_MSB:`EXT_MODE_LSB],
                        freq: sfr_wdata_i[`EXT_FREQ_MSB:`EXT_FREQ_LSB]};
      if (sfr_rd_i)
        rdata_q <= rdata_d;
    end
  end

  // Low-frequency oscillator emulation; stopped means counter held at zero
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lf_cnt_q     <= 8'h00;
      lf_raw_q     <= 1'b0;
      lf_div_cnt_q <= 3'h0;
      lf_clk_q     <= 1'b0;
    end
    else
    begin
      lf_cnt_q     <= (!lf_ctrl_q.en || lf_wrap) ? 8'h00 : lf_cnt_q + 8'h01;  // see [RULE1]
      lf_raw_q     <= lf_ctrl_q.en && (lf_raw_q ^ lf_wrap);
      lf_div_cnt_q <= (!lf_ctrl_q.en || div_chg) ? 3'h0 : lf_div_cnt_q + {2'h0, lf_rise};
      lf_clk_q     <= lf_ctrl_q.en && lf_div_sel;
    end
  end

  // Ready survives a disable; only a divider change drops it, and that
  // clear beats a coincident settle because the settle was for the old ratio
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lf_settle_q <= 2'h0;
      lf_rdy_q    <= 1'b0;
    end
    else
    begin
      if (div_chg || !lf_ctrl_q.en)
        lf_settle_q <= 2'h0;
      else if (lf_out_rise && !lf_rdy_q && !lf_settled)
        lf_settle_q <= lf_settle_q + 2'h1;
      if (div_chg)
        lf_rdy_q <= 1'b0;  // see [RULE3]
      // A settle seen in the cycle of a disable must not raise ready
      else if (lf_settled && lf_ctrl_q.en)
        lf_rdy_q <= 1'b1;  // see [RULE2] see [RULE16]
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ext_state_q <= EXT_OFF;
      pin_q       <= 1'b0;
      ext_half_q  <= 1'b0;
      ext_clk_q   <= 1'b0;
      ext_edge_q  <= 5'h00;
      src_ext_q   <= 1'b0;
      in_claim_q  <= 1'b0;
      out_claim_q <= 1'b0;
    end
    else
    begin
      ext_state_q <= ext_state_d;
      pin_q       <= osc_pin_out_i;
      ext_half_q  <= ext_on && (ext_half_q ^ ext_rise);
      ext_clk_q   <= ext_on && (ext_div2 ? ext_half_q : pin_q);  // see [RULE11]
      // Count from zero again when the mode changes during the wait
      ext_edge_q  <= (ext_state_q != EXT_WAIT || ext_restart) ? 5'h00 : ext_edge_q + {4'h0, ext_rise};  // see [RULE12]
      src_ext_q   <= sysclk_ext_sel_i && ext_on;  // see [RULE9]
      in_claim_q  <= ext_on && ext_is_xtal(ext_ctrl_q.mode);  // see [RULE8]
      out_claim_q <= ext_on;
    end
  end

  assign sfr_rdata_o         = rdata_q;
  assign lf_clk_o            = lf_clk_q;
  assign ext_clk_o           = ext_clk_q;
  assign sysclk_src_ext_o    = src_ext_q;
  assign osc_pin_in_claim_o  = in_claim_q;
  assign osc_pin_out_claim_o = out_claim_q;

  lf_stop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE1]
    !lf_ctrl_q.en |=> !lf_clk_q && (lf_cnt_q == 8'h00))
    else $error("low-frequency output active while disabled");
  rdy_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE3]
    $fell(lf_rdy_q) |-> $past(div_chg))
    else $error("ready dropped without divider change");
  rdy_set_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE16]
    $rose(lf_rdy_q) |-> $past(lf_ctrl_q.en) && $past(lf_out_rise) && !$past(div_chg))
    else $error("ready set without settled output");
  half_period_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE4]
    (lf_ctrl_q.en && $past(lf_ctrl_q.en) && $changed(lf_raw_q)) |->
      $past(lf_cnt_q) == $past(lf_half) - 8'h01)
    else $error("half period does not match trim");
  div_eight_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE6]
    ($rose(lf_clk_q) && lf_ctrl_q.div == `LF_DIV_BY8 && !$past(div_chg)) |-> $past(lf_div_cnt_q) == 3'h4)
    else $error("divide by eight misaligned");
  reg_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE7]
    (sfr_rd_i && sfr_addr_i == `LF_CTRL_ADDR) |=> sfr_rdata_o == $past(lf_rd_word))
    else $error("control register read mismatch");
  pin_claim_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE8]
    osc_pin_in_claim_o |-> osc_pin_out_claim_o && ext_is_xtal($past(ext_ctrl_q.mode)))
    else $error("first pin claimed outside crystal mode");
  half_clock_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE11]
    (ext_div2 && $past(ext_div2, 2) && ext_on && $past(ext_on, 2) && $changed(ext_clk_q)) |->
      $past(ext_rise, 2))
    else $error("halved clock changed without input edge");
  valid_set_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE12]
    $rose(ext_valid) |-> $past(ext_state_q == EXT_WAIT) && $past(ext_rise) && ext_on)
    else $error("valid set without qualified edges");
  src_ext_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // see [RULE9]
    sysclk_src_ext_o |-> $past(ext_on) && $past(sysclk_ext_sel_i))
    else $error("system clock switched to idle source");

  rdy_seen_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(lf_rdy_q));
  rdy_redo_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) $fell(lf_rdy_q) ##[1:1000] lf_out_rise);
  ext_valid_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(ext_valid) && ext_div2);

endmodule
`default_nettype wire

// ---- ext_osc_model.sv ----
// External oscillator source driving the second oscillator pin
`timescale 1ns/100ps
`default_nettype none
module ext_osc_model
#(
  parameter int HALF = 4
)
(
  input  wire logic sys_clk_i,
  input  wire logic run_i,
  output var  logic pin_o
);
  int cnt_q;
  // Stopped oscillator sits low, no free run outside enable
  always_ff @(posedge sys_clk_i)
  begin
    cnt_q <= (run_i && cnt_q < HALF - 1) ? cnt_q + 1 : 0;
    pin_o <= run_i ? (cnt_q == HALF - 1 ? ~pin_o : pin_o) : 1'b0;
  end
endmodule
`default_nettype wire

// ---- lowfreq_osc_and_ext_osc_ctrl_bench.sv ----
// Self-checking bench for the oscillator control block
`timescale 1ns/100ps
`default_nettype none
`include "lfosc_params.svh"
module lowfreq_osc_and_ext_osc_ctrl_bench;
  logic       clk = 0, rst = 1, wr = 0, rd = 0, sel = 0, run = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  wire  [7:0] rdata;
  wire        pin, lf_clk, ext_clk, src_ext, claim_in, claim_out;
  int         err_count = 0, compares = 0, cyc = 0;

  initial forever #25 clk = ~clk;

  ext_osc_model #(.HALF(4)) osc (.sys_clk_i(clk), .run_i(run), .pin_o(pin));

  lfosc_ctrl DUT (.sys_clk_i(clk), .rst_i(rst), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .osc_pin_out_i(pin),
    .sysclk_ext_sel_i(sel), .lf_clk_o(lf_clk), .ext_clk_o(ext_clk),
    .sysclk_src_ext_o(src_ext), .osc_pin_in_claim_o(claim_in), .osc_pin_out_claim_o(claim_out));

  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Tests take about 31000 cycles, most of it the oscillator start wait
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_count++;
      final_report();
    end
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    check("rdata", rdata, exp);
  endtask

  // A ratio or mode write may cut the first two halves short; check the next high and low
  task automatic half_per(input bit ext, input int exp);
    logic v;
    int   n;
    @(negedge clk);
    for (int k = 0; k < 4; k++)
    begin
      v = ext ? ext_clk : lf_clk;
      n = 0;
      while ((ext ? ext_clk : lf_clk) === v)
      begin
        @(negedge clk);
        n++;
      end
      if (k > 1)
        check(ext ? "ext half" : "lf half", n[15:0], exp[15:0]);
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`LF_CTRL_ADDR, 8'h20);
    rd_chk(`EXT_CTRL_ADDR, 8'h00);
    rd_chk(8'h87, 8'h00);
    for (int d = 0; d < 4; d++)
    begin
      wr_reg(`LF_CTRL_ADDR, 8'ha0 | d[7:0]);
      half_per(1'b0, `LF_HALF_NOM << (3 - d));
    end
    repeat (600) @(posedge clk);
    rd_chk(`LF_CTRL_ADDR, 8'he3);
    wr_reg(`LF_CTRL_ADDR, 8'he3);
    rd_chk(`LF_CTRL_ADDR, 8'he3);
    wr_reg(`LF_CTRL_ADDR, 8'ha2);
    rd_chk(`LF_CTRL_ADDR, 8'ha2);
    repeat (900) @(posedge clk);
    rd_chk(`LF_CTRL_ADDR, 8'he2);
    half_per(1'b0, 250);
    // Trim altered only while stopped; a stop alone keeps ready
    wr_reg(`LF_CTRL_ADDR, 8'h22);
    rd_chk(`LF_CTRL_ADDR, 8'h62);
    check("lf stop", lf_clk, 1'b0);
    wr_reg(`LF_CTRL_ADDR, 8'h03);
    wr_reg(`LF_CTRL_ADDR, 8'h83);
    half_per(1'b0, 93);
    wr_reg(`LF_CTRL_ADDR, 8'h3f);
    wr_reg(`LF_CTRL_ADDR, 8'hbf);
    half_per(1'b0, 153);
    // Oscillator model started before the crystal mode write hands it both pins
    @(posedge clk);
    run <= 1'b1;
    wr_reg(`EXT_CTRL_ADDR, 8'h63);
    rd_chk(`EXT_CTRL_ADDR, 8'h63);
    check("pin claims", {claim_in, claim_out}, 2'b11);
    repeat (20000) @(posedge clk);
    rd_chk(`EXT_CTRL_ADDR, 8'he3);
    @(posedge clk);
    sel <= 1'b1;
    repeat (3) @(negedge clk);
    check("sysclk ext", src_ext, 1'b1);
    half_per(1'b1, 4);
    wr_reg(`EXT_CTRL_ADDR, 8'h73);
    half_per(1'b1, 8);
    repeat (200) @(posedge clk);
    rd_chk(`EXT_CTRL_ADDR, 8'hf3);
    wr_reg(`EXT_CTRL_ADDR, 8'h23);
    rd_chk(`EXT_CTRL_ADDR, 8'h23);
    check("pin claims", {claim_in, claim_out}, 2'b01);
    wr_reg(`EXT_CTRL_ADDR, 8'h03);
    rd_chk(`EXT_CTRL_ADDR, 8'h03);
    check("src and claims", {src_ext, claim_in, claim_out}, 3'b000);
    final_report();
  end
endmodule
`default_nettype wire
